// ==== core/flash_poll_pkg.sv ====
package flash_poll_pkg;
  // status byte bit positions
  localparam int unsigned DATA_POLL_BIT_POS = 7;
  localparam int unsigned PRIMARY_TOGGLE_POS = 6;
  localparam int unsigned TIME_LIMIT_POS = 5;
  localparam int unsigned ERASE_WINDOW_POS = 3;
  localparam int unsigned SECTOR_TOGGLE_POS = 2;
  // software register offsets (word index on the plain port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_RDATA = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h5;
  localparam logic [3:0] REG_IRQ_EN = 4'h6;
  localparam logic [3:0] REG_IRQ_CLR = 4'h7;
  // control register command codes
  localparam logic [2:0] CMD_POLL = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_READ = 3'h3;
  localparam logic [2:0] CMD_ERASE_ADD = 3'h4;
  // event bits in irq registers
  localparam int unsigned EV_DONE_OK = 0;
  localparam int unsigned EV_FAIL = 1;
  localparam int unsigned EV_REJECT = 2;
  localparam int unsigned EV_NUM = 3;
  // reset command data and sector erase confirm data
  localparam logic [7:0] RESET_CMD_DATA = 8'hf0;
  localparam logic [7:0] SECTOR_ERASE_DATA = 8'h30;
  // flash bus timing in ns
  localparam int unsigned T_ACCESS_NS = 70;
  localparam int unsigned T_WPULSE_NS = 35;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WPULSE_CYC = (T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // poll outcome encodings
  typedef enum logic [1:0] {
    RES_NONE = 2'b00,
    RES_OK = 2'b01,
    RES_FAIL = 2'b10,
    RES_REJECT = 2'b11
  } poll_result_t;
endpackage : flash_poll_pkg

// ==== core/flash_bus_cycle.sv ====
// one flash bus cycle: read or write, strobes low for a fixed pulse
module flash_bus_cycle
  import flash_poll_pkg::*;
#(
  parameter int unsigned ADDR_W = 21,
  parameter int unsigned DATA_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  input wire logic [DATA_W-1:0] flash_dq_i,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o
);
  localparam int unsigned CNT_W = 8;
  typedef struct packed {
    logic busy;
    logic wr;
    logic done;
    logic [CNT_W-1:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
  } cyc_state_t;
  cyc_state_t s_r;
  cyc_state_t s_nxt;

  // strobe timing: reads wait the access time, writes hold the pulse width
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy && start_i) begin
      s_nxt.busy = 1'b1;
      s_nxt.wr = write_i;
      s_nxt.addr = addr_i;
      s_nxt.wdata = wdata_i;
      s_nxt.cnt = write_i ? CNT_W'(WPULSE_CYC) : CNT_W'(ACCESS_CYC);
    end else if (s_r.busy) begin
      if (s_r.cnt == '0) begin
        // strobe rises here; the read sample is taken before release
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        if (!s_r.wr) begin
          s_nxt.rdata = flash_dq_i;
        end
      end else begin
        s_nxt.cnt = s_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done_o = s_r.done;
  assign rdata_o = s_r.rdata;
  assign flash_addr_o = s_r.addr;
  assign flash_ce_n_o = ~s_r.busy;
  assign flash_oe_n_o = ~(s_r.busy & ~s_r.wr);
  assign flash_we_n_o = ~(s_r.busy & s_r.wr);
  assign flash_dq_o = s_r.wdata;
  assign flash_dq_oe_o = s_r.busy & s_r.wr;
endmodule : flash_bus_cycle

// ==== core/flash_poll_ctrl.sv ====
// The address map and the address-and-strobe port are this design's own decisions.
module flash_poll_ctrl
  import flash_poll_pkg::*;
#(
  parameter int unsigned ADDR_W = 21,
  parameter int unsigned DATA_W = 8,
  parameter int unsigned REG_AW = 4
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [REG_AW-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  input wire logic [DATA_W-1:0] flash_dq_i,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic ready_busy_out_i
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_WR = 4'b0001,
    ST_RD = 4'b0010,
    ST_P1 = 4'b0011,
    ST_P2 = 4'b0100,
    ST_P3 = 4'b0101,
    ST_RST = 4'b0110,
    ST_ARRAY = 4'b0111,
    ST_EW_PRE = 4'b1000,
    ST_EW_CMD = 4'b1001,
    ST_EW_POST = 4'b1010
  } fsm_t;

  typedef struct packed {
    fsm_t st;
    logic cyc_go;
    logic cyc_wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] first;
    logic busy;
    logic ew_pre;
    poll_result_t result;
    logic [EV_NUM-1:0] irq_stat;
    logic [EV_NUM-1:0] irq_en;
    logic [31:0] rd_out;
  } ctrl_state_t;

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic [EV_NUM-1:0] ev;

  // either toggle alone counts
  // toggle of the two toggle bits between two reads
  function automatic logic toggled(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    toggled = (a[PRIMARY_TOGGLE_POS] != b[PRIMARY_TOGGLE_POS]) ||
              (a[SECTOR_TOGGLE_POS] != b[SECTOR_TOGGLE_POS]);
  endfunction : toggled

  flash_bus_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_cycle (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .start_i(s_r.cyc_go),
    .write_i(s_r.cyc_wr),
    .addr_i(s_r.addr),
    .wdata_i(s_r.wdata),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .flash_addr_o(flash_addr_o),
    .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o),
    .flash_we_n_o(flash_we_n_o),
    .flash_dq_i(flash_dq_i),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o)
  );

  // sequencer, register file and event capture in one next-state block
  always_comb begin
    s_nxt = s_r;
    s_nxt.cyc_go = 1'b0;
    ev = '0;
    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.busy = 1'b0;
      end
      ST_WR, ST_RD, ST_ARRAY, ST_RST: begin
        if (cyc_done) begin
          s_nxt.rdata = cyc_rdata;
          s_nxt.st = ST_IDLE;
          s_nxt.busy = 1'b0;
        end
      end
      ST_P1: begin
        if (cyc_done) begin
          s_nxt.first = cyc_rdata;
          s_nxt.cyc_go = 1'b1;
          s_nxt.st = ST_P2;
        end
      end
      ST_P2: begin
        if (cyc_done) begin
          s_nxt.rdata = cyc_rdata;
          if (!toggled(s_r.first, cyc_rdata)) begin
            s_nxt.result = RES_OK;
            s_nxt.cyc_go = 1'b1;
            s_nxt.st = ST_ARRAY;
            ev[EV_DONE_OK] = 1'b1;
          end else if (cyc_rdata[TIME_LIMIT_POS]) begin
            // time limit seen: one more read, compared with this one
            s_nxt.first = cyc_rdata;
            s_nxt.cyc_go = 1'b1;
            s_nxt.st = ST_P3;
          end else begin
            // keep polling from the first read
            s_nxt.cyc_go = 1'b1;
            s_nxt.st = ST_P1;
          end
        end
      end
      ST_P3: begin
        if (cyc_done) begin
          s_nxt.rdata = cyc_rdata;
          if (!toggled(s_r.first, cyc_rdata)) begin
            s_nxt.result = RES_OK;
            s_nxt.cyc_go = 1'b1;
            s_nxt.st = ST_ARRAY;
            ev[EV_DONE_OK] = 1'b1;
          end else begin
            s_nxt.result = RES_FAIL;
            s_nxt.cyc_wr = 1'b1;
            s_nxt.wdata = RESET_CMD_DATA;
            s_nxt.cyc_go = 1'b1;
            s_nxt.st = ST_RST;
            ev[EV_FAIL] = 1'b1;
          end
        end
      end
      ST_EW_PRE: begin
        // window always checked, no spacing assumed
        if (cyc_done) begin
          s_nxt.rdata = cyc_rdata;
          s_nxt.ew_pre = cyc_rdata[ERASE_WINDOW_POS];
          s_nxt.cyc_wr = 1'b1;
          s_nxt.cyc_go = 1'b1;
          s_nxt.st = ST_EW_CMD;
        end
      end
      ST_EW_CMD: begin
        if (cyc_done) begin
          s_nxt.cyc_wr = 1'b0;
          s_nxt.cyc_go = 1'b1;
          s_nxt.st = ST_EW_POST;
        end
      end
      ST_EW_POST: begin
        // window closed means the command may be lost
        if (cyc_done) begin
          s_nxt.rdata = cyc_rdata;
          s_nxt.st = ST_IDLE;
          s_nxt.busy = 1'b0;
          // window already closed before the command counts as lost too
          if (cyc_rdata[ERASE_WINDOW_POS] || s_r.ew_pre) begin
            s_nxt.result = RES_REJECT;
            ev[EV_REJECT] = 1'b1;
          end else begin
            s_nxt.result = RES_OK;
            ev[EV_DONE_OK] = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    // commands from software, only taken while idle
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_ADDR: s_nxt.addr = reg_wdata_i[ADDR_W-1:0];
        REG_WDATA: s_nxt.wdata = reg_wdata_i[DATA_W-1:0];
        REG_IRQ_EN: s_nxt.irq_en = reg_wdata_i[EV_NUM-1:0];
        REG_CTRL: begin
          if (s_r.st == ST_IDLE) begin
            s_nxt.busy = 1'b1;
            s_nxt.result = RES_NONE;
            s_nxt.cyc_go = 1'b1;
            s_nxt.cyc_wr = 1'b0;
            unique case (reg_wdata_i[2:0])
              CMD_WRITE: begin
                s_nxt.cyc_wr = 1'b1;
                s_nxt.st = ST_WR;
              end
              CMD_READ: s_nxt.st = ST_RD;
              // poll at the busy bank's valid address
              CMD_POLL: s_nxt.st = ST_P1;
              CMD_ERASE_ADD: begin
                s_nxt.wdata = SECTOR_ERASE_DATA;
                s_nxt.st = ST_EW_PRE;
              end
              default: begin
                s_nxt.busy = 1'b0;
                s_nxt.cyc_go = 1'b0;
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end

    // sticky events: set wins over a clear in the same cycle
    s_nxt.irq_stat = (s_r.irq_stat &
      ~((reg_wr_i && reg_addr_i == REG_IRQ_CLR) ? reg_wdata_i[EV_NUM-1:0] : '0)) | ev;

    // read data stands one cycle after the strobe
    s_nxt.rd_out = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_ADDR: s_nxt.rd_out = 32'(s_r.addr);
        REG_WDATA: s_nxt.rd_out = 32'(s_r.wdata);
        // busy bit, poll result and ready/busy line
        REG_STATUS: s_nxt.rd_out = {28'h0, ready_busy_out_i, s_r.result, s_r.busy};
        REG_RDATA: s_nxt.rd_out = 32'(s_r.rdata);
        REG_IRQ_STAT: s_nxt.rd_out = 32'(s_r.irq_stat);
        REG_IRQ_EN: s_nxt.rd_out = 32'(s_r.irq_en);
        default: s_nxt.rd_out = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata_o = s_r.rd_out;
  // level interrupt while any enabled event is pending
  assign irq_o = |(s_r.irq_stat & s_r.irq_en);
endmodule : flash_poll_ctrl

// ==== verification/flash_poll_monitor.sv ====
module flash_poll_monitor (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic irq_o,
  input wire logic [20:0] flash_addr_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_dq_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  // register port and flash strobe discipline
  a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  a_strobes_apart: assert property (flash_oe_n_o || flash_we_n_o)
    else $error("both flash strobes low");
  a_read_selected: assert property (!flash_oe_n_o |-> !flash_ce_n_o && !flash_dq_oe_o)
    else $error("read strobe without select or with drive");
  a_write_driven: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_dq_oe_o)
    else $error("write strobe without select or drive");
  a_read_pulse: assert property ($fell(flash_oe_n_o) |-> ##18 !flash_oe_n_o ##1 flash_oe_n_o)
    else $error("read pulse length wrong");
  a_write_pulse: assert property ($fell(flash_we_n_o) |-> ##9 !flash_we_n_o ##1 flash_we_n_o)
    else $error("write pulse length wrong");
  a_addr_held: assert property (!flash_ce_n_o && $past(!flash_ce_n_o) |-> $stable(flash_addr_o))
    else $error("address moved inside a cycle");
  a_wdata_held: assert property (!flash_we_n_o && $past(!flash_we_n_o) |-> $stable(flash_dq_o))
    else $error("write data moved inside a pulse");
  // main activity seen
  c_irq: cover property ($rose(irq_o));
  c_write: cover property ($fell(flash_we_n_o));
  c_read: cover property ($fell(flash_oe_n_o));
endmodule : flash_poll_monitor

bind flash_poll_ctrl flash_poll_monitor i_mon (
  .clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .irq_o(irq_o),
  .flash_addr_o(flash_addr_o),
  .flash_ce_n_o(flash_ce_n_o),
  .flash_oe_n_o(flash_oe_n_o),
  .flash_we_n_o(flash_we_n_o),
  .flash_dq_o(flash_dq_o),
  .flash_dq_oe_o(flash_dq_oe_o)
);

// ==== verification/flash_status_model.sv ====
module flash_status_model
  import flash_poll_pkg::*;
(
  input wire logic [20:0] addr_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic ready_busy_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // state poked by the bench to pick the operation
  int busy_left = 0;
  bit erasing = 1'b0;
  bit hang = 1'b0;
  bit suspended = 1'b0;
  bit window = 1'b0;
  bit got_reset = 1'b0;
  bit tog6 = 1'b0;
  bit tog2 = 1'b0;
  logic [7:0] array_byte = 8'ha5;
  logic [7:0] last = 8'h00;
  logic [7:0] wr_byte = 8'h00;
  logic busy;
  logic [7:0] status;
  assign busy = (busy_left > 0) || hang;
  // suspended sector: polling bit high, primary toggle still, ready high
  assign status = suspended ? {1'b1, tog6, 3'b000, tog2, 2'b00}
                : erasing ? {1'b0, tog6, hang && busy_left == 0, 1'b0, window, tog2, 2'b00}
                          : {~array_byte[7], tog6, hang && busy_left == 0, 2'b00, tog2, 2'b00};
  assign ready_busy_out_o = !busy;
  // only bank 0 busy; released bus shows inverse of last byte
  always_comb begin
    if (!oe_n_i) begin
      dq_o = ((busy || suspended) && !addr_i[20]) ? status : array_byte;
    end else begin
      dq_o = ~last;
    end
  end
  always @(posedge oe_n_i) begin
    last <= dq_o;
    if ((busy || suspended) && !addr_i[20]) begin
      tog6 <= suspended ? tog6 : ~tog6;
      tog2 <= (erasing || suspended) ? ~tog2 : tog2;
      busy_left <= (busy_left > 0) ? busy_left - 1 : 0;
    end
  end
  // reset command ends a stalled operation
  always @(posedge we_n_i) begin
    wr_byte <= dq_i;
    if (dq_i == RESET_CMD_DATA) begin
      hang <= 1'b0;
      busy_left <= 0;
      got_reset <= 1'b1;
    end
  end
endmodule : flash_status_model

// ==== verification/flash_poll_ctrl_tb_top.sv ====
module flash_poll_ctrl_tb_top
  import flash_poll_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [31:0] v;
  logic [31:0] first_byte;
  logic irq_o;
  logic flash_oe_n_o;
  logic flash_we_n_o;
  logic ready_busy;
  logic [20:0] flash_addr_o;
  logic [7:0] flash_dq_o;
  logic [7:0] flash_dq_i;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  flash_poll_ctrl i_dut (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o),
    .flash_addr_o(flash_addr_o),
    .flash_ce_n_o(),
    .flash_oe_n_o(flash_oe_n_o),
    .flash_we_n_o(flash_we_n_o),
    .flash_dq_i(flash_dq_i),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(),
    .ready_busy_out_i(ready_busy)
  );
  flash_status_model i_flash (
    .addr_i(flash_addr_o),
    .oe_n_i(flash_oe_n_o),
    .we_n_i(flash_we_n_o),
    .dq_i(flash_dq_o),
    .dq_o(flash_dq_i),
    .ready_busy_out_o(ready_busy)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  task automatic expect_reg(input logic [3:0] a, input logic [31:0] exp);
    rd(a);
    check(v, exp);
  endtask : expect_reg
  // start a command, then poll the busy bit; a hang is cut by the cycle ceiling
  task automatic go(input logic [2:0] cmd);
    wr(REG_CTRL, {29'h0, cmd});
    v = 32'h1;
    while (v[0] !== 1'b0) rd(REG_STATUS);
  endtask : go
  // ceiling well above the several hundred cycles the sequence needs
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    expect_reg(REG_STATUS, 32'h8);
    expect_reg(REG_IRQ_STAT, 32'h0);
    expect_reg(4'hf, 32'h0);
    wr(REG_IRQ_EN, 32'h7);
    wr(REG_ADDR, 32'h100);
    // program: busy seen mid-run, then array byte after the toggle stops
    i_flash.busy_left = 4;
    wr(REG_CTRL, {29'h0, CMD_POLL});
    expect_reg(REG_STATUS, 32'h1);
    go(CMD_POLL);
    expect_reg(REG_STATUS, 32'ha);
    expect_reg(REG_RDATA, 32'ha5);
    check({31'h0, irq_o}, 32'h1);
    expect_reg(REG_IRQ_STAT, 32'h1);
    wr(REG_IRQ_CLR, 32'h7);
    // erase with both toggles running
    i_flash.erasing = 1'b1;
    i_flash.busy_left = 6;
    go(CMD_POLL);
    expect_reg(REG_STATUS, 32'ha);
    wr(REG_IRQ_CLR, 32'h7);
    // stalled operation with the event masked
    wr(REG_IRQ_EN, 32'h0);
    i_flash.hang = 1'b1;
    i_flash.busy_left = 3;
    go(CMD_POLL);
    expect_reg(REG_STATUS, 32'hc);
    check({31'h0, i_flash.got_reset}, 32'h1);
    check({31'h0, irq_o}, 32'h0);
    expect_reg(REG_IRQ_STAT, 32'h2);
    wr(REG_IRQ_EN, 32'h7);
    repeat (2) @(posedge clk_sys_i);
    check({31'h0, irq_o}, 32'h1);
    wr(REG_IRQ_CLR, 32'h7);
    // idle bank returns plain data while the other is busy
    i_flash.busy_left = 50;
    wr(REG_ADDR, 32'h100000);
    go(CMD_POLL);
    expect_reg(REG_STATUS, 32'h2);
    expect_reg(REG_RDATA, 32'ha5);
    wr(REG_ADDR, 32'h100);
    // added sector inside the window is taken
    i_flash.busy_left = 20;
    wr(REG_IRQ_CLR, 32'h7);
    go(CMD_ERASE_ADD);
    check({24'h0, i_flash.wr_byte}, {24'h0, SECTOR_ERASE_DATA});
    rd(REG_IRQ_STAT);
    check({31'h0, v[EV_REJECT]}, 32'h0);
    // window closed: the add is reported as refused
    i_flash.window = 1'b1;
    wr(REG_IRQ_CLR, 32'h7);
    go(CMD_ERASE_ADD);
    i_flash.busy_left = 0;
    repeat (4) @(posedge clk_sys_i);
    expect_reg(REG_STATUS, 32'he);
    rd(REG_IRQ_STAT);
    check({31'h0, v[EV_REJECT]}, 32'h1);
    // plain write and read commands; a suspended sector shows its own pattern
    wr(REG_WDATA, {24'h0, RESET_CMD_DATA});
    go(CMD_WRITE);
    check({24'h0, i_flash.wr_byte}, {24'h0, RESET_CMD_DATA});
    i_flash.suspended = 1'b1;
    go(CMD_READ);
    expect_reg(REG_STATUS, 32'h8);
    rd(REG_RDATA);
    first_byte = v;
    check({31'h0, v[DATA_POLL_BIT_POS]}, 32'h1);
    go(CMD_READ);
    rd(REG_RDATA);
    check({31'h0, v[SECTOR_TOGGLE_POS] ^ first_byte[SECTOR_TOGGLE_POS]}, 32'h1);
    check({31'h0, v[PRIMARY_TOGGLE_POS] ^ first_byte[PRIMARY_TOGGLE_POS]}, 32'h0);
    conclude();
  end
endmodule : flash_poll_ctrl_tb_top
